/* design/maint_defines.svh */
`ifndef MAINT_DEFINES_SVH
`define MAINT_DEFINES_SVH

// Timing.
`define HOUR_S        64'he10
`define CLK_HZ        64'h989680

// Menu selection.
`define FULL_MENU     2'h2
`define MAINT_MENU    3'h5
`define MENU_LAST     3'h7
`define ITEM_LAST     4'ha

// Counter limits and reset values.
`define RT_SAT        17'h18696
`define TEMP_FLOOR    8'h14
`define PCT_FULL      32'h64
`define ENERGY_WRAP   24'h989680
`define DERIVED_SAT   24'h989298
`define DISP_MAX      32'h270f
`define DISP_STEP1    32'h2710
`define DISP_STEP2    32'h186a0
`define DISP_STEP3    32'hf4240

// Display decimal point positions.
`define DP_ONES       2'h0
`define DP_TENTHS     2'h1
`define DP_HUNDREDTHS 2'h2
`define DP_THOUSANDTHS 2'h3

`endif

/* design/maint_pkg.sv */
package maint_pkg;

  typedef enum logic [3:0] {
    ST_RUN  = 4'b0001,
    ST_FUNC = 4'b0010,
    ST_LIST = 4'b0100,
    ST_DATA = 4'b1000
  } menu_state_type;

  typedef struct packed {
    menu_state_type state;
    logic [2:0]     menu_sel;
    logic [3:0]     item_sel;
    logic [35:0]    hour_cnt;
    logic [15:0]    pon_hours;
    logic [16:0]    cap_hours;
    logic [16:0]    fan_hours;
    logic [15:0]    starts;
    logic [7:0]     int_run;
    logic [7:0]     hs_run;
    logic [15:0]    cur_run;
    logic [7:0]     int_pk;
    logic [7:0]     hs_pk;
    logic [15:0]    cur_pk;
    logic [15:0]    cap_pct;
    logic [23:0]    energy;
    logic [23:0]    derived;
    logic [13:0]    disp_val;
    logic [1:0]     disp_dp;
  } maint_state_type;

endpackage

/* design/maintenance_counters.sv */
`timescale 1ns/10ps
`include "maint_defines.svh"

module maintenance_counters
  import maint_pkg::*;
#(
  parameter longint unsigned HOUR_CYCLES = `HOUR_S * `CLK_HZ
) (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Keypad keys, one-cycle pulses.
  input  wire logic        key_prog,
  input  wire logic        key_up,
  input  wire logic        key_down,
  input  wire logic        key_enter,
  input  wire logic        key_back,
  // Settings.
  input  wire logic [1:0]  menu_depth_select,
  input  wire logic [23:0] energy_coefficient,
  input  wire logic        coef_write,
  input  wire logic        fan_onoff_control,
  // Drive status.
  input  wire logic        fan_running,
  input  wire logic        run_cmd,
  input  wire logic        energy_tick,
  input  wire logic [15:0] dc_bus_volts,
  input  wire logic [7:0]  temp_internal,
  input  wire logic [7:0]  temp_heatsink,
  input  wire logic [15:0] rms_current,
  input  wire logic [15:0] cap_now,
  input  wire logic [15:0] cap_ship,
  // Monitor outputs.
  output logic [3:0]       menu_state,
  output logic [2:0]       menu_sel,
  output logic [3:0]       item_sel,
  output logic [13:0]      disp_val,
  output logic [1:0]       disp_dp
);

  localparam logic [35:0] HOUR_LAST = 36'(HOUR_CYCLES - 64'h1);

  maint_state_type st_q;
  maint_state_type st_d;
  logic            hour_tick;
  logic            full_menu;
  logic [47:0]     prod;
  logic [47:0]     derived_calc;
  logic [31:0]     pct_calc;

  // Scales a value held in thousandths to four digits and a point position.
  function automatic logic [15:0] fit4(input logic [31:0] m);
    logic [31:0] v;
    logic [1:0]  dp;
    v  = m;
    dp = `DP_THOUSANDTHS;
    if (m >= `DISP_STEP3) begin
      v  = m / 32'h3e8;
      dp = `DP_ONES;
    end else if (m >= `DISP_STEP2) begin
      v  = m / 32'h64;
      dp = `DP_TENTHS;
    end else if (m >= `DISP_STEP1) begin
      v  = m / 32'ha;
      dp = `DP_HUNDREDTHS;
    end
    if (v > `DISP_MAX) begin
      v = `DISP_MAX;
    end
    return {dp, v[13:0]};
  endfunction

  // Shows a whole number clamped to four digits.
  function automatic logic [15:0] plain4(input logic [31:0] m);
    logic [31:0] v;
    v = (m > `DISP_MAX) ? `DISP_MAX : m;
    return {`DP_ONES, v[13:0]};
  endfunction

  function automatic logic [7:0] floor20(input logic [7:0] t);
    return (t < `TEMP_FLOOR) ? `TEMP_FLOOR : t;
  endfunction

  assign hour_tick    = (st_q.hour_cnt == HOUR_LAST);
  assign full_menu    = (menu_depth_select == `FULL_MENU);
  assign prod         = 48'(st_q.energy) * 48'(energy_coefficient);
  assign derived_calc = prod / 48'ha;
  assign pct_calc     = (cap_ship == 16'h0) ? 32'h0
                        : (32'(cap_now) * `PCT_FULL) / 32'(cap_ship);

  always_comb begin
    st_d = st_q;

    // Menu navigation.
    unique case (st_q.state)
      ST_RUN: begin
        if (key_prog) begin
          st_d.state = ST_FUNC;
        end
      end
      ST_FUNC: begin
        if (key_prog) begin
          st_d.state = ST_RUN;
        end else if (key_up) begin
          st_d.menu_sel = (st_q.menu_sel == `MENU_LAST) ? 3'h0 : st_q.menu_sel + 3'h1;
        end else if (key_down) begin
          st_d.menu_sel = (st_q.menu_sel == 3'h0) ? `MENU_LAST : st_q.menu_sel - 3'h1;
        end else if (key_enter && st_q.menu_sel == `MAINT_MENU && full_menu) begin
          st_d.state    = ST_LIST;
          st_d.item_sel = 4'h0;
        end
      end
      ST_LIST: begin
        if (!full_menu || key_back) begin
          st_d.state = ST_FUNC;
        end else if (key_up) begin
          st_d.item_sel = (st_q.item_sel == `ITEM_LAST) ? 4'h0 : st_q.item_sel + 4'h1;
        end else if (key_down) begin
          st_d.item_sel = (st_q.item_sel == 4'h0) ? `ITEM_LAST : st_q.item_sel - 4'h1;
        end else if (key_enter) begin
          st_d.state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (!full_menu) begin
          st_d.state = ST_FUNC;
        end else if (key_back) begin
          st_d.state = ST_LIST;
        end
      end
      default: begin
        st_d.state = ST_RUN;
      end
    endcase

    // Hour tick divider.
    st_d.hour_cnt = hour_tick ? 36'h0 : st_q.hour_cnt + 36'h1;

    // Run-time counters.
    if (hour_tick) begin
      st_d.pon_hours = st_q.pon_hours + 16'h1;
      if (st_q.cap_hours < `RT_SAT) begin
        st_d.cap_hours = st_q.cap_hours + 17'h1;
      end
      if (st_q.fan_hours < `RT_SAT && !(fan_onoff_control && !fan_running)) begin
        st_d.fan_hours = st_q.fan_hours + 17'h1;
      end
    end

    if (run_cmd) begin
      st_d.starts = st_q.starts + 16'h1;
    end

    // Hourly peaks.
    if (hour_tick) begin
      st_d.int_pk  = floor20((temp_internal > st_q.int_run) ? temp_internal : st_q.int_run);
      st_d.hs_pk   = floor20((temp_heatsink > st_q.hs_run) ? temp_heatsink : st_q.hs_run);
      st_d.cur_pk  = (rms_current > st_q.cur_run) ? rms_current : st_q.cur_run;
      st_d.int_run = temp_internal;
      st_d.hs_run  = temp_heatsink;
      st_d.cur_run = rms_current;
    end else begin
      st_d.int_run = (temp_internal > st_q.int_run) ? temp_internal : st_q.int_run;
      st_d.hs_run  = (temp_heatsink > st_q.hs_run) ? temp_heatsink : st_q.hs_run;
      st_d.cur_run = (rms_current > st_q.cur_run) ? rms_current : st_q.cur_run;
    end

    st_d.cap_pct = (pct_calc > 32'hffff) ? 16'hffff : pct_calc[15:0];

    // Energy accumulation, held in thousandths of a kWh.
    if (energy_tick) begin
      st_d.energy = (st_q.energy >= `ENERGY_WRAP) ? 24'h0 : st_q.energy + 24'h1;
    end
    st_d.derived = (derived_calc > 48'(`DERIVED_SAT)) ? `DERIVED_SAT : derived_calc[23:0];
    if (coef_write && energy_coefficient == 24'h0) begin
      st_d.energy  = 24'h0;
      st_d.derived = 24'h0;
    end

    // Display selection.
    if (st_q.state == ST_DATA) begin
      unique case (st_q.item_sel)
        4'h0:    {st_d.disp_dp, st_d.disp_val} = fit4(32'(st_q.pon_hours));
        4'h1:    {st_d.disp_dp, st_d.disp_val} = plain4(32'(dc_bus_volts));
        4'h2:    {st_d.disp_dp, st_d.disp_val} = plain4(32'(st_q.int_pk));
        4'h3:    {st_d.disp_dp, st_d.disp_val} = plain4(32'(st_q.hs_pk));
        4'h4:    {st_d.disp_dp, st_d.disp_val} = plain4(32'(st_q.cur_pk));
        4'h5:    {st_d.disp_dp, st_d.disp_val} = plain4(32'(st_q.cap_pct));
        4'h6:    {st_d.disp_dp, st_d.disp_val} = fit4(32'(st_q.cap_hours));
        4'h7:    {st_d.disp_dp, st_d.disp_val} = fit4(32'(st_q.fan_hours));
        4'h8:    {st_d.disp_dp, st_d.disp_val} = fit4(32'(st_q.starts));
        4'h9:    {st_d.disp_dp, st_d.disp_val} = fit4(32'(st_q.energy));
        4'ha:    {st_d.disp_dp, st_d.disp_val} = fit4(32'(st_q.derived));
        default: {st_d.disp_dp, st_d.disp_val} = {`DP_ONES, 14'h0};
      endcase
    end else begin
      st_d.disp_dp  = `DP_ONES;
      st_d.disp_val = {10'h0, st_q.item_sel};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q           <= '0;
      st_q.state     <= ST_RUN;
      st_q.int_pk    <= `TEMP_FLOOR;
      st_q.hs_pk     <= `TEMP_FLOOR;
    end else begin
      st_q <= st_d;
    end
  end

  assign menu_state = st_q.state;
  assign menu_sel   = st_q.menu_sel;
  assign item_sel   = st_q.item_sel;
  assign disp_val   = st_q.disp_val;
  assign disp_dp    = st_q.disp_dp;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  AST_MENU_DEPTH: assert property (
    (st_q.state inside {ST_LIST, ST_DATA}) && !full_menu |=> st_q.state == ST_FUNC
  ) else $error("Maintenance items stayed reachable outside full menu.");

  AST_BACK_KEY: assert property (
    st_q.state == ST_DATA && full_menu && key_back |=> st_q.state == ST_LIST ##0
    st_q.item_sel == $past(st_q.item_sel)
  ) else $error("Back key from data did not return to item list.");

  AST_PON_WRAP: assert property (
    hour_tick && st_q.pon_hours == 16'hffff |=> st_q.pon_hours == 16'h0
  ) else $error("Power-on hours did not wrap to zero.");

  AST_RT_SAT: assert property (
    st_q.cap_hours <= `RT_SAT && st_q.fan_hours <= `RT_SAT
  ) else $error("Run-time counter passed its ceiling.");

  AST_FAN_GATE: assert property (
    fan_onoff_control && !fan_running |=> $stable(st_q.fan_hours)
  ) else $error("Fan hours advanced while fan stopped under control.");

  AST_START_INC: assert property (
    run_cmd |=> st_q.starts == $past(st_q.starts) + 16'h1
  ) else $error("Startup counter did not step on run command.");

  AST_TEMP_FLOOR: assert property (
    st_q.int_pk >= `TEMP_FLOOR && st_q.hs_pk >= `TEMP_FLOOR
  ) else $error("Temperature peak below floor.");

  AST_PEAK_HOLD: assert property (
    !hour_tick |=> $stable(st_q.cur_pk) && $stable(st_q.int_pk)
  ) else $error("Peak display changed outside the hour boundary.");

  AST_ENERGY_CLR: assert property (
    coef_write && energy_coefficient == 24'h0 |=> st_q.energy == 24'h0 && st_q.derived == 24'h0
  ) else $error("Zero coefficient did not clear energy values.");

  AST_DERIVED_SAT: assert property (
    st_q.derived <= `DERIVED_SAT
  ) else $error("Derived energy passed its saturation value.");

  AST_PON_STEP: assert property (
    hour_tick |=> st_q.pon_hours == $past(st_q.pon_hours) + 16'h1
  ) else $error("Power-on hours did not step on the hour tick.");

  AST_PON_HOLD: assert property (
    !hour_tick |=> $stable(st_q.pon_hours)
  ) else $error("Power-on hours changed between hour ticks.");

  AST_CAP_STEP: assert property (
    hour_tick && st_q.cap_hours < `RT_SAT |=> st_q.cap_hours == $past(st_q.cap_hours) + 17'h1
  ) else $error("Capacitor hours did not step on the hour tick.");

  AST_CAP_STOP: assert property (
    st_q.cap_hours == `RT_SAT |=> st_q.cap_hours == `RT_SAT
  ) else $error("Capacitor hours left their ceiling.");

  AST_FAN_STEP: assert property (
    hour_tick && st_q.fan_hours < `RT_SAT && !fan_onoff_control
    |=> st_q.fan_hours == $past(st_q.fan_hours) + 17'h1
  ) else $error("Fan hours did not step with fan control off.");

  AST_START_WRAP: assert property (
    run_cmd && st_q.starts == 16'hffff |=> st_q.starts == 16'h0
  ) else $error("Startup counter did not wrap to zero.");

  AST_START_HOLD: assert property (
    !run_cmd |=> $stable(st_q.starts)
  ) else $error("Startup counter changed without a run command.");

  AST_ENERGY_WRAP: assert property (
    energy_tick && !(coef_write && energy_coefficient == 24'h0) && st_q.energy >= `ENERGY_WRAP
    |=> st_q.energy == 24'h0
  ) else $error("Energy did not return to zero past its limit.");

  AST_ENERGY_STEP: assert property (
    energy_tick && !(coef_write && energy_coefficient == 24'h0) && st_q.energy < `ENERGY_WRAP
    |=> st_q.energy == $past(st_q.energy) + 24'h1
  ) else $error("Energy did not step on an energy tick.");

  AST_HS_PEAK: assert property (
    hour_tick |=> st_q.hs_pk >= $past(temp_heatsink)
  ) else $error("Heat-sink peak below the last sample.");

  AST_CUR_PEAK: assert property (
    hour_tick |=> st_q.cur_pk >= $past(rms_current)
  ) else $error("Current peak below the last sample.");

  AST_RUN_RESTART: assert property (
    hour_tick |=> st_q.cur_run == $past(rms_current)
  ) else $error("Running current maximum did not restart at the hour.");

  AST_DISP_LIST: assert property (
    st_q.state != ST_DATA |=> st_q.disp_val == {10'h0, $past(st_q.item_sel)}
  ) else $error("Display did not show the item index outside data state.");

  AST_DISP_RANGE: assert property (
    st_q.disp_val <= 14'h270f
  ) else $error("Display value passed four digits.");

  AST_DATA_ENTRY: assert property (
    st_q.state == ST_FUNC && key_enter && !key_prog && !key_up && !key_down && !full_menu
    |=> st_q.state != ST_LIST
  ) else $error("Item list entered outside full menu.");

  COV_DATA_SHOWN: cover property (st_q.state == ST_LIST ##1 st_q.state == ST_DATA);
  COV_FAN_RUN: cover property (hour_tick && !fan_onoff_control && st_q.fan_hours != 17'h0);
  COV_PON_WRAP: cover property (hour_tick && st_q.pon_hours == 16'hffff);
  COV_FAN_SAT: cover property (st_q.fan_hours == `RT_SAT);
  COV_ENERGY_CLR: cover property (coef_write && energy_coefficient == 24'h0 && st_q.energy != 24'h0);

endmodule

/* verif/keypad_model.sv */
`timescale 1ns/10ps

// Keypad front panel: one key pulse at a time, one cycle long.
module keypad_model (
  // Clock.
  input  wire logic ref_clk,
  // Key pulses.
  output logic      key_prog,
  output logic      key_up,
  output logic      key_down,
  output logic      key_enter,
  output logic      key_back
);
  logic [4:0] keys;

  assign {key_back, key_enter, key_down, key_up, key_prog} = keys;

  initial begin
    keys = 5'h00;
  end

  // Key codes: 0 prog, 1 up, 2 down, 3 enter, 4 back.
  task automatic press(input int k);
    @(posedge ref_clk);
    #1 keys = 5'h01 << k;
    @(posedge ref_clk);
    #1 keys = 5'h00;
  endtask
endmodule

/* verif/maintenance_counters_tb.sv */
`timescale 1ns/10ps

module maintenance_counters_tb;
  import maint_pkg::*;

  logic        ref_clk, rst_n, key_prog, key_up, key_down, key_enter, key_back;
  logic [1:0]  menu_depth_select;
  logic [23:0] energy_coefficient;
  logic        coef_write, fan_onoff_control, fan_running, run_cmd, energy_tick;
  logic [15:0] dc_bus_volts, rms_current, cap_now, cap_ship;
  logic [7:0]  temp_internal, temp_heatsink;
  logic [3:0]  menu_state, item_sel;
  logic [2:0]  menu_sel;
  logic [13:0] disp_val;
  logic [1:0]  disp_dp;
  int          error_cnt, comparisons, n_start, n_energy;
  logic [31:0] seed;
  logic [15:0] got;

  maintenance_counters #(.HOUR_CYCLES(8)) maintenance_counters_inst (.*);
  keypad_model keypad_model_inst (.*);

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Expected {dp, value} of a scaled count.
  function automatic logic [15:0] scaled(input int n);
    if (n < 10000) return {2'h3, 14'(n)};
    if (n < 100000) return {2'h2, 14'(n / 10)};
    if (n < 1000000) return {2'h1, 14'(n / 100)};
    return {2'h0, 14'(n / 1000)};
  endfunction

  // Expected capacitance percentage against the shipment value.
  function automatic logic [31:0] pct_exp(input logic [15:0] n, input logic [15:0] s);
    if (s == 16'h0) return 32'h0;
    return (32'(n) * 32'h64) / 32'(s);
  endfunction

  // From the function menu on the maintenance entry, shows one item and returns.
  task automatic view(input int it);
    keypad_model_inst.press(3);
    repeat (it) keypad_model_inst.press(1);
    keypad_model_inst.press(3);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("data state", 32'(menu_state), 32'h8);
    got = {disp_dp, disp_val};
    keypad_model_inst.press(4);
    keypad_model_inst.press(4);
  endtask

  task automatic pulse_n(input int n, input bit en);
    repeat (n) begin
      @(posedge ref_clk);
      #1 {run_cmd, energy_tick} = en ? 2'b01 : 2'b10;
      @(posedge ref_clk);
      #1 {run_cmd, energy_tick} = 2'b00;
    end
  endtask

  initial begin
    #2000000;
    error_cnt++;
    end_sim();
  end

  initial begin
    seed = 32'h75a3;
    rst_n = 1'b0;
    menu_depth_select = 2'h1;
    energy_coefficient = 24'h000000;
    {coef_write, run_cmd, energy_tick, fan_running} = 4'h0;
    fan_onoff_control = 1'b1;
    dc_bus_volts = 16'($random(seed)) & 16'h1fff;
    rms_current = 16'($random(seed)) & 16'h1fff;
    cap_now = 16'($random(seed)) & 16'h003f;
    cap_ship = 16'h0064;
    temp_internal = 8'h05;
    temp_heatsink = 8'h14 + (8'($random(seed)) & 8'h3f);
    n_start = 1 + ($random(seed) & 8'hff);
    n_energy = 16 + ($random(seed) & 8'hff);
    repeat (16) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    keypad_model_inst.press(0);
    repeat (5) keypad_model_inst.press(1);
    keypad_model_inst.press(3);
    @(posedge ref_clk);
    #1;
    chk("refused entry", 32'(menu_state), 32'h2);
    chk("menu index", 32'(menu_sel), 32'h5);
    menu_depth_select = 2'h2;
    keypad_model_inst.press(3);
    @(posedge ref_clk);
    #1;
    chk("item list", 32'(menu_state), 32'h4);
    chk("first item", 32'(item_sel), 32'h0);
    keypad_model_inst.press(4);
    @(posedge ref_clk);
    #1;
    chk("back to menu", 32'(menu_state), 32'h2);
    pulse_n(n_start, 1'b0);
    pulse_n(n_energy, 1'b1);
    repeat (40) @(posedge ref_clk);
    view(1);
    chk("bus volts", 32'(got[13:0]), 32'(dc_bus_volts));
    view(2);
    chk("internal peak", 32'(got[13:0]), 32'h14);
    view(3);
    chk("heatsink peak", 32'(got[13:0]), 32'(temp_heatsink));
    view(4);
    chk("current peak", 32'(got[13:0]), 32'(rms_current));
    view(5);
    chk("capacitance", 32'(got[13:0]), pct_exp(cap_now, cap_ship));
    view(7);
    chk("fan hours", 32'(got), 32'(scaled(0)));
    view(8);
    chk("startups", 32'(got), 32'(scaled(n_start)));
    view(9);
    chk("energy", 32'(got), 32'(scaled(n_energy)));
    #1 energy_coefficient = 24'd9999000;
    view(10);
    chk("derived sat", 32'(got), 32'(scaled(9999000)));
    @(posedge ref_clk);
    #1 energy_coefficient = 24'h000000;
    coef_write = 1'b1;
    @(posedge ref_clk);
    #1 coef_write = 1'b0;
    view(9);
    chk("energy clear", 32'(got), 32'(scaled(0)));
    view(10);
    chk("derived clear", 32'(got), 32'(scaled(0)));
    fan_onoff_control = 1'b0;
    fan_running = 1'($random(seed));
    temp_internal = 8'h20 + (8'($random(seed)) & 8'h1f);
    rms_current = 16'($random(seed)) & 16'h0fff;
    dc_bus_volts = 16'($random(seed)) & 16'h1fff;
    cap_ship = 16'h0032;
    repeat (40) @(posedge ref_clk);
    view(1);
    chk("bus volts new", 32'(got[13:0]), 32'(dc_bus_volts));
    view(2);
    chk("internal peak new", 32'(got[13:0]), 32'(temp_internal));
    view(4);
    chk("current peak new", 32'(got[13:0]), 32'(rms_current));
    view(5);
    chk("capacitance new", 32'(got[13:0]), pct_exp(cap_now, cap_ship));
    view(7);
    chk("fan hours run", 32'(got != scaled(0)), 32'h1);
    view(0);
    chk("power-on dp", 32'(got[15:14]), 32'h3);
    chk("power-on run", 32'(got[13:0] != 14'h0), 32'h1);
    view(6);
    chk("capacitor dp", 32'(got[15:14]), 32'h3);
    chk("capacitor run", 32'(got[13:0] != 14'h0), 32'h1);
    end_sim();
  end
endmodule
